// >>> design/lvs_supervisor.v
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lvs_consts.vh"
// What this block does
// - detector enable output follows detect_enable, forced off in stop unless detect_stop_enable is set.
// - in stop, detection runs only if detect_stop_enable is set.
// - both enables set turns a stop request into shallow stop.
// - after power-on, reset held until supply above low threshold.
// - power-on sets both power-on and low-voltage reset-source flags.
// - detect_reset_enable set plus low supply while detection runs gives system reset.
// - after low-voltage reset, hold reset until supply recovers.
// - low-voltage reset sets low-voltage reset-source flag.
// - enabled detect with irq and no reset sets detect_flag, irq.
// - writing one to detect_flag_ack clears detect_flag.
// - warning comparator sets warning_flag while supply is still above the detect trip.
// - warning_irq_enable with warning_flag raises warning request.
// - writing one to warning_flag_ack clears warning_flag.
module lvs_supervisor #(
  parameter MIN_RST_CYC = `LVS_MIN_RST_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // analog side
  input wire por_i,
  input wire below_detect_i,
  input wire below_warn_i,
  output wire detect_on_o,
  // stop control
  input wire stop_req_i,
  input wire wake_i,
  output reg [1:0] stop_mode_o,
  // system reset and interrupts
  output wire sys_reset_o,
  output wire detect_irq_o,
  output wire warning_irq_o,
  output wire irq_o
);
  wire [2:0] sync_out;
  wire por_s;
  wire low_s;
  wire warn_s;
  reg [7:0] ctrl1;
  reg [7:0] ctrl3;
  reg detect_flag;
  reg warning_flag;
  reg rs_por;
  reg rs_lvd;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg hold_rst;
  reg [7:0] rst_cnt;
  reg low_q;
  reg [7:0] hist;
  wire detect_enable;
  wire detect_stop_enable;
  wire detect_reset_enable;
  wire detect_irq_enable;
  wire warning_irq_enable;
  wire in_stop;
  wire det_active;
  wire low_ev;
  wire lv_reset;
  wire wr_c1;
  wire wr_c3;
  wire det_set;
  wire warn_set;
  wire stop_ev;
  reg [7:0] next_rdata;
  // last count value of the minimum hold, cut to the counter's width
  localparam integer RST_LAST_I = MIN_RST_CYC - 1;
  localparam [7:0] RST_LAST = RST_LAST_I[7:0];

  // por and detect inputs sit high in reset (warning low) so the block starts as if power just came up
  lvs_sync #(
    .WIDTH(3),
    .RST_VAL(3'b011)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({below_warn_i, below_detect_i, por_i}),
    .sync_o(sync_out)
  );
  assign por_s = sync_out[0];
  assign low_s = sync_out[1];
  assign warn_s = sync_out[2];

  assign detect_enable = ctrl1[`LVS_C1_DETE];
  assign detect_stop_enable = ctrl1[`LVS_C1_DETSE];
  assign detect_reset_enable = ctrl1[`LVS_C1_DETRE];
  assign detect_irq_enable = ctrl1[`LVS_C1_DETIE];
  assign warning_irq_enable = ctrl3[`LVS_C3_WARNIE];

  assign in_stop = (stop_mode_o != `LVS_STOP_NONE);
  assign det_active = detect_enable && (!in_stop || detect_stop_enable);
  assign detect_on_o = det_active;
  assign low_ev = det_active && low_s;
  assign lv_reset = low_ev && detect_reset_enable;

  assign wr_c1 = wr_i && (addr_i == `LVS_ADDR_CTRL1);
  assign wr_c3 = wr_i && (addr_i == `LVS_ADDR_CTRL3);
  assign det_set = low_ev && detect_irq_enable && !detect_reset_enable;
  // warning only counts while supply is still above the detect trip
  assign warn_set = warn_s && !low_s;
  assign stop_ev = stop_req_i && !in_stop && !hold_rst;

  // stop entry and exit
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_mode_o <= `LVS_STOP_NONE;
    end else if (hold_rst || wake_i) begin
      stop_mode_o <= `LVS_STOP_NONE;
    end else if (stop_ev) begin
      if (detect_enable && detect_stop_enable) begin
        stop_mode_o <= `LVS_STOP_SHALLOW;
      end else begin
        stop_mode_o <= `LVS_STOP_DEEP;
      end
    end
  end

  // reset hold: kept until supply is back above the trip and a minimum
  // width has passed, so a glitchy recovery cannot chatter the reset
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_rst <= 1'b1;
      rst_cnt <= 8'h00;
    end else if (por_s || lv_reset) begin
      hold_rst <= 1'b1;
      rst_cnt <= 8'h00;
    end else if (hold_rst) begin
      if (low_s) begin
        rst_cnt <= 8'h00;
      end else if (rst_cnt >= RST_LAST) begin
        hold_rst <= 1'b0;
      end else begin
        rst_cnt <= rst_cnt + 8'h01;
      end
    end
  end
  assign sys_reset_o = hold_rst;

  // reset source flags survive the system reset they report
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rs_por <= 1'b1;
      rs_lvd <= 1'b1;
    end else if (por_s) begin
      rs_por <= 1'b1;
      rs_lvd <= 1'b1;
    end else if (lv_reset) begin
      rs_por <= 1'b0;
      rs_lvd <= 1'b1;
    end
  end

  // control registers; flags: set wins over acknowledge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl1 <= `LVS_C1_RESET;
      ctrl3 <= `LVS_C3_RESET;
      detect_flag <= 1'b0;
      warning_flag <= 1'b0;
    end else if (hold_rst) begin
      ctrl1 <= `LVS_C1_RESET;
      ctrl3 <= `LVS_C3_RESET;
      detect_flag <= 1'b0;
      warning_flag <= warn_set;
    end else begin
      if (wr_c1) begin
        ctrl1 <= wdata_i & 8'h3C;
      end
      if (wr_c3) begin
        ctrl3 <= wdata_i & 8'h08;
      end
      if (det_set) begin
        detect_flag <= 1'b1;
      end else if (wr_c1 && wdata_i[`LVS_C1_DETACK]) begin
        detect_flag <= 1'b0;
      end
      if (warn_set) begin
        warning_flag <= 1'b1;
      end else if (wr_c3 && wdata_i[`LVS_C3_WARNACK]) begin
        warning_flag <= 1'b0;
      end
    end
  end

  assign detect_irq_o = detect_flag && detect_irq_enable;
  assign warning_irq_o = warning_flag && warning_irq_enable;

  // sticky event status, write one to clear, set wins
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_i && addr_i == `LVS_ADDR_IRQMSK) begin
        irq_mask <= wdata_i[2:0];
      end
      irq_stat <= (irq_stat & ~((wr_i && addr_i == `LVS_ADDR_IRQST)
                  ? wdata_i[2:0] : 3'h0))
                  | {stop_ev, warning_irq_o, detect_irq_o};
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  // low-voltage event counter for diagnostics
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_q <= 1'b0;
      hist <= `LVS_HIST_RESET;
    end else begin
      low_q <= low_ev;
      if (wr_i && addr_i == `LVS_ADDR_HIST) begin
        hist <= `LVS_HIST_RESET;
      end else if (low_ev && !low_q && hist != 8'hFF) begin
        hist <= hist + 8'h01;
      end
    end
  end

  // read mux; acknowledge bits read as zero
  always @* begin
    next_rdata = 8'h00;
    case (addr_i)
      `LVS_ADDR_CTRL1: begin
        next_rdata = ctrl1;
        next_rdata[`LVS_C1_DETF] = detect_flag;
      end
      `LVS_ADDR_CTRL3: begin
        next_rdata = ctrl3;
        next_rdata[`LVS_C3_WARNF] = warning_flag;
      end
      `LVS_ADDR_RSTSRC: begin
        next_rdata[`LVS_RS_POR] = rs_por;
        next_rdata[`LVS_RS_LVD] = rs_lvd;
      end
      `LVS_ADDR_IRQST: next_rdata = {5'h00, irq_stat};
      `LVS_ADDR_IRQMSK: next_rdata = {5'h00, irq_mask};
      `LVS_ADDR_HIST: next_rdata = hist;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // lvs_supervisor
`default_nettype wire

// >>> design/lvs_consts.vh
`ifndef LVS_CONSTS_VH
`define LVS_CONSTS_VH
// register addresses (byte-wide registers on a plain port)
`define LVS_ADDR_CTRL1 4'h0
`define LVS_ADDR_CTRL3 4'h1
`define LVS_ADDR_RSTSRC 4'h2
`define LVS_ADDR_IRQST 4'h3
`define LVS_ADDR_IRQMSK 4'h4
`define LVS_ADDR_HIST 4'h5
// power_control_one fields
`define LVS_C1_DETF 7
`define LVS_C1_DETACK 6
`define LVS_C1_DETIE 5
`define LVS_C1_DETRE 4
`define LVS_C1_DETSE 3
`define LVS_C1_DETE 2
// power_control_three fields
`define LVS_C3_WARNF 7
`define LVS_C3_WARNACK 6
`define LVS_C3_WARNIE 3
// reset_source_status fields
`define LVS_RS_POR 7
`define LVS_RS_LVD 1
// interrupt status fields
`define LVS_IS_DET 0
`define LVS_IS_WARN 1
`define LVS_IS_STOP 2
// reset values
`define LVS_C1_RESET 8'h1C
`define LVS_C3_RESET 8'h00
`define LVS_MSK_RESET 8'h00
`define LVS_HIST_RESET 8'h00
// stop mode encodings
`define LVS_STOP_NONE 2'h0
`define LVS_STOP_SHALLOW 2'h1
`define LVS_STOP_DEEP 2'h2
// timing
`define LVS_SYNC_STAGES 2
`define LVS_CLK_NS 4
`define LVS_MIN_RST_NS 40
`define LVS_MIN_RST_CYC ((`LVS_MIN_RST_NS + `LVS_CLK_NS - 1) / `LVS_CLK_NS)
`endif

// >>> design/lvs_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser per bit
module lvs_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // data
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta <= RST_VAL[g];
          stable <= RST_VAL[g];
        end else begin
          meta <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate
endmodule // lvs_sync
`default_nettype wire

// >>> dv/lvs_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvs_consts.vh"
module lvs_supervisor_asserts #(
  parameter MIN_RST_CYC = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  // analog and control
  input wire logic por_i,
  input wire logic below_detect_i,
  input wire logic below_warn_i,
  input wire logic detect_on_o,
  input wire logic [1:0] stop_mode_o,
  input wire logic sys_reset_o,
  input wire logic detect_irq_o,
  input wire logic warning_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // consecutive cycles of healthy supply, saturating
  logic [7:0] good_cnt;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      good_cnt <= 8'h00;
    else if (por_i || below_detect_i)
      good_cnt <= 8'h00;
    else if (good_cnt != 8'hFF)
      good_cnt <= good_cnt + 8'h01;
  end
  a_shallow_keeps_det: assert property (
    stop_mode_o == `LVS_STOP_SHALLOW |-> detect_on_o) else $error("det off");
  a_deep_drops_det: assert property (
    stop_mode_o == `LVS_STOP_DEEP |-> !detect_on_o) else $error("det on");
  a_det_irq_cause: assert property (
    $rose(detect_irq_o) && !$past(wr_i) |-> $past(below_detect_i, 3))
    else $error("det irq early");
  a_warn_irq_cause: assert property (
    $rose(warning_irq_o) && !$past(wr_i) |-> $past(below_warn_i, 3))
    else $error("warn irq early");
  a_por_holds_reset: assert property (
    por_i [*3] |=> sys_reset_o) else $error("no hold");
  a_release_when_good: assert property (
    $fell(sys_reset_o) |-> good_cnt >= MIN_RST_CYC) else $error("early");
  a_det_ack_clears: assert property (
    wr_i && addr_i == `LVS_ADDR_CTRL1 && wdata_i[`LVS_C1_DETACK]
    && wdata_i[`LVS_C1_DETIE] && !sys_reset_o && !below_detect_i
    && !$past(below_detect_i) && !$past(below_detect_i, 2)
    |=> !detect_irq_o) else $error("det ack");
  a_warn_ack_clears: assert property (
    wr_i && addr_i == `LVS_ADDR_CTRL3 && wdata_i[`LVS_C3_WARNACK]
    && wdata_i[`LVS_C3_WARNIE] && !sys_reset_o && !below_warn_i
    && !$past(below_warn_i) && !$past(below_warn_i, 2)
    |=> !warning_irq_o) else $error("warn ack");
  c_shallow: cover property (stop_mode_o == `LVS_STOP_SHALLOW);
  c_deep: cover property (stop_mode_o == `LVS_STOP_DEEP);
  c_release: cover property ($fell(sys_reset_o));
endmodule // lvs_supervisor_asserts
`default_nettype wire

// >>> dv/lvs_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
// level: 0 off, 1 below detect, 2 warning band, 3 good
module lvs_supply_model (
  input wire logic clk_i,
  input wire logic [1:0] level_i,
  input wire logic detect_on_i,
  output logic por_o = 1'b1,
  output logic below_detect_o = 1'b0,
  output logic below_warn_o = 1'b0
);
  // a powered-down detector reports nothing, so no free warning either
  always @(posedge clk_i) begin
    por_o <= level_i == 2'h0;
    below_detect_o <= detect_on_i && level_i < 2'h2;
    below_warn_o <= detect_on_i && level_i < 2'h3;
  end
endmodule // lvs_supply_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvs_consts.vh"
module tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stop_req_i = 1'b0;
  logic wake_i = 1'b0;
  logic [1:0] level = 2'h0;
  wire [7:0] rdata_o;
  wire [1:0] stop_mode_o;
  wire por_i, below_detect_i, below_warn_i, detect_on_o;
  wire sys_reset_o, detect_irq_o, warning_irq_o, irq_o;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2 clk_i = ~clk_i;
  lvs_supply_model model (.clk_i(clk_i), .level_i(level),
    .detect_on_i(detect_on_o), .por_o(por_i),
    .below_detect_o(below_detect_i), .below_warn_o(below_warn_i));
  lvs_supervisor #(.MIN_RST_CYC(2)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .por_i(por_i), .below_detect_i(below_detect_i),
    .below_warn_i(below_warn_i), .detect_on_o(detect_on_o),
    .stop_req_i(stop_req_i), .wake_i(wake_i), .stop_mode_o(stop_mode_o),
    .sys_reset_o(sys_reset_o), .detect_irq_o(detect_irq_o),
    .warning_irq_o(warning_irq_o), .irq_o(irq_o));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  // bounded wait for the reset hold to let go
  task up;
    int i;
    for (i = 0; i < 100 && sys_reset_o !== 1'b0; i++) @(posedge clk_i);
    if (sys_reset_o !== 1'b0) begin
      n_mismatch++;
      conclude;
    end
    #1;
  endtask
  task stop(input logic [1:0] m);
    @(posedge clk_i);
    stop_req_i <= 1'b1;
    @(posedge clk_i);
    stop_req_i <= 1'b0;
    #1 check(stop_mode_o, m);
    check(detect_on_o, m == `LVS_STOP_SHALLOW);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    #1 check(stop_mode_o, `LVS_STOP_NONE);
  endtask
  task t_por;
    cyc(10);
    check(sys_reset_o, 1'b1);
    level <= 2'h3;
    up;
    rd(`LVS_ADDR_RSTSRC, 8'h82);
    rd(`LVS_ADDR_CTRL1, `LVS_C1_RESET);
  endtask
  task t_detect;
    wr(`LVS_ADDR_CTRL1, 8'h24);
    wr(`LVS_ADDR_IRQMSK, 8'h01);
    wr(`LVS_ADDR_HIST, 8'h00);
    level <= 2'h1;
    cyc(5);
    rd(`LVS_ADDR_HIST, 8'h01);
    check(detect_irq_o, 1'b1);
    check(sys_reset_o, 1'b0);
    rd(`LVS_ADDR_CTRL1, 8'hA4);
    level <= 2'h3;
    cyc(4);
    wr(`LVS_ADDR_CTRL1, 8'h64);
    cyc(1);
    check(detect_irq_o, 1'b0);
    check(irq_o, 1'b1);
    wr(`LVS_ADDR_IRQMSK, 8'h00);
    cyc(1);
    check(irq_o, 1'b0);
    wr(`LVS_ADDR_IRQST, 8'h01);
    wr(`LVS_ADDR_IRQMSK, 8'h01);
    cyc(1);
    check(irq_o, 1'b0);
  endtask
  task t_warn;
    wr(`LVS_ADDR_CTRL3, 8'h08);
    level <= 2'h2;
    cyc(5);
    check(warning_irq_o, 1'b1);
    check(detect_irq_o, 1'b0);
    level <= 2'h3;
    cyc(4);
    wr(`LVS_ADDR_CTRL3, 8'h48);
    cyc(1);
    check(warning_irq_o, 1'b0);
  endtask
  task t_stop;
    wr(`LVS_ADDR_CTRL1, 8'h00);
    cyc(1);
    check(detect_on_o, 1'b0);
    wr(`LVS_ADDR_CTRL1, 8'h0C);
    stop(`LVS_STOP_SHALLOW);
    wr(`LVS_ADDR_CTRL1, 8'h04);
    wr(`LVS_ADDR_IRQST, 8'h07);
    stop(`LVS_STOP_DEEP);
    rd(`LVS_ADDR_IRQST, 8'h04);
  endtask
  task t_lvd_reset;
    wr(`LVS_ADDR_CTRL1, 8'h14);
    level <= 2'h1;
    cyc(20);
    check(sys_reset_o, 1'b1);
    level <= 2'h3;
    up;
    rd(`LVS_ADDR_RSTSRC, 8'h02);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_por;
    t_detect;
    t_warn;
    t_stop;
    t_lvd_reset;
    conclude;
  end
endmodule // tb
bind lvs_supervisor lvs_supervisor_asserts #(.MIN_RST_CYC(MIN_RST_CYC)) chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .por_i(por_i), .below_detect_i(below_detect_i),
  .below_warn_i(below_warn_i), .detect_on_o(detect_on_o),
  .stop_mode_o(stop_mode_o), .sys_reset_o(sys_reset_o),
  .detect_irq_o(detect_irq_o), .warning_irq_o(warning_irq_o));
`default_nettype wire
